// *** serial_pkg.sv ***
// Shared constants and state types for the four-channel serial port block.
package serial_pkg;

  // ----------------------------------------------------------------
  // Clock and baud rate limits
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_MIN = 300;
  localparam int BAUD_MAX = 57600;
  localparam int BAUD_DEFAULT = 9600;
  localparam int DIV_W = 18;
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
  localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / BAUD_DEFAULT);

  // ----------------------------------------------------------------
  // Framing encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] LEN_CODE_8 = 2'h3;
  localparam logic [2:0] LEN_BASE_IDX = 3'h4;
  localparam logic TWO_STOP_DEFAULT = 1'b0;
  localparam logic [1:0] LINE_RS232 = 2'h0;
  localparam logic [1:0] LINE_RS422 = 2'h1;
  localparam logic [1:0] LINE_RS485 = 2'h2;
  localparam int NUM_PORTS = 4;
  localparam int NUM_MODEM = 2;
  localparam int TX_FIFO_DEPTH = 32;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

endpackage

// *** sync_fifo.sv ***
// Synchronous FIFO with a registered read stage.
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = (count_reg != '0) && (!out_valid || out_ready);

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_ptr_reg <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
      end
      count_reg <= count_next;
      in_ready <= (count_next != FULL_CNT);
    end
  end

  // The output word sits in a register so the read path has no memory-to-pin timing.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_data <= '0;
      out_valid <= 1'b0;
    end else if (pop) begin
      out_data <= mem[rd_ptr_reg];
      out_valid <= 1'b1;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// *** quad_async_serial_ports.sv ***
// Four asynchronous serial ports with modem lines and selectable line modes.
// Summary of operation
// - Each port runs at any software baud divisor between 300 and 57600 baud.
// - Reset leaves every port at 9600 baud, eight data bits, no parity, one stop.
// - An abort request restores every port to its reset framing and rate.
// - Four ports, each with its own configuration, transmitter and receiver.
// - Ports three and four select single-ended, four-wire or two-wire differential mode.
// - Ports one and two drive RTS and DTR and sample CTS, DSR and DCD.
// - Every bit lasts one baud period, so a character's time follows the rate.
module quad_async_serial_ports (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Configuration
  input wire logic abort_req,
  input wire logic [serial_pkg::NUM_PORTS-1:0] cfg_write,
  input wire logic [serial_pkg::DIV_W-1:0] cfg_baud_div,
  input wire logic [1:0] cfg_parity,
  input wire logic [1:0] cfg_len,
  input wire logic cfg_two_stop,
  input wire logic [1:0] cfg_line_mode,
  output wire logic [serial_pkg::NUM_PORTS-1:0][serial_pkg::DIV_W-1:0] cur_baud_div,
  // Transmit data
  input wire logic [serial_pkg::NUM_PORTS-1:0][7:0] tx_data,
  input wire logic [serial_pkg::NUM_PORTS-1:0] tx_valid,
  output wire logic [serial_pkg::NUM_PORTS-1:0] tx_ready,
  output wire logic [serial_pkg::NUM_PORTS-1:0] tx_busy,
  // Receive data
  output wire logic [serial_pkg::NUM_PORTS-1:0][7:0] rx_data,
  output wire logic [serial_pkg::NUM_PORTS-1:0] rx_valid,
  output wire logic [serial_pkg::NUM_PORTS-1:0] rx_parity_err,
  output wire logic [serial_pkg::NUM_PORTS-1:0] rx_frame_err,
  // Serial lines
  output wire logic [serial_pkg::NUM_PORTS-1:0] txd,
  input wire logic [serial_pkg::NUM_PORTS-1:0] rxd,
  // Modem lines of the first two ports
  input wire logic [serial_pkg::NUM_MODEM-1:0] rts_req,
  input wire logic [serial_pkg::NUM_MODEM-1:0] dtr_req,
  input wire logic [serial_pkg::NUM_MODEM-1:0] cts_flow_en,
  input wire logic [serial_pkg::NUM_MODEM-1:0] cts_in,
  input wire logic [serial_pkg::NUM_MODEM-1:0] dsr_in,
  input wire logic [serial_pkg::NUM_MODEM-1:0] dcd_in,
  output logic [serial_pkg::NUM_MODEM-1:0] rts_out,
  output logic [serial_pkg::NUM_MODEM-1:0] dtr_out,
  output logic [serial_pkg::NUM_MODEM-1:0] cts_stat,
  output logic [serial_pkg::NUM_MODEM-1:0] dsr_stat,
  output logic [serial_pkg::NUM_MODEM-1:0] dcd_stat,
  // Line drivers of the last two ports
  output wire logic [1:0][1:0] line_mode,
  output wire logic [1:0] drv_en,
  output wire logic [1:0] rcv_en
);
  import serial_pkg::*;

  // ----------------------------------------------------------------
  // Modem handshake lines
  // ----------------------------------------------------------------
  logic [NUM_MODEM-1:0] cts_s1_reg, dsr_s1_reg, dcd_s1_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rts_out <= '0;
      dtr_out <= '0;
      cts_s1_reg <= '0;
      dsr_s1_reg <= '0;
      dcd_s1_reg <= '0;
      cts_stat <= '0;
      dsr_stat <= '0;
      dcd_stat <= '0;
    end else begin
      rts_out <= rts_req;
      dtr_out <= dtr_req;
      cts_s1_reg <= cts_in;
      dsr_s1_reg <= dsr_in;
      dcd_s1_reg <= dcd_in;
      cts_stat <= cts_s1_reg;
      dsr_stat <= dsr_s1_reg;
      dcd_stat <= dcd_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Per-port channel
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    logic [DIV_W-1:0] div_reg;
    logic [1:0] par_reg, len_reg, mode_reg;
    logic stop2_reg;
    logic cts_ok;
    logic [7:0] f_data;
    logic f_valid, f_ready;
    tx_state_t tx_state;
    logic [DIV_W-1:0] tx_cnt_reg;
    logic [2:0] tx_idx_reg;
    logic [7:0] tx_sh_reg;
    logic tx_par_reg, tx_stop_reg, txd_reg;
    logic tx_go, tx_done, tx_active_next, busy_reg, drv_reg, rcv_reg;
    logic [7:0] len_mask;
    logic [2:0] last_idx;
    logic is_two_wire;
    logic rx_s1_reg, rx_s2_reg, rx_line;
    rx_state_t rx_state;
    logic [DIV_W-1:0] rx_cnt_reg;
    logic [2:0] rx_idx_reg;
    logic [7:0] rx_sh_reg, rx_aligned;
    logic rx_par_bit_reg;
    logic [7:0] rx_data_reg;
    logic rx_valid_reg, rx_perr_reg, rx_ferr_reg;
    assign len_mask = 8'hff >> (2'h3 - len_reg);
    assign last_idx = LEN_BASE_IDX + {1'b0, len_reg};
    assign is_two_wire = (mode_reg == LINE_RS485);
    // Configuration. An out-of-range divisor is ignored so the rate always stays legal.
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        div_reg <= DIV_DEFAULT;
        par_reg <= PAR_NONE;
        len_reg <= LEN_CODE_8;
        stop2_reg <= TWO_STOP_DEFAULT;
        mode_reg <= LINE_RS232;
      end else if (abort_req) begin
        div_reg <= DIV_DEFAULT;
        par_reg <= PAR_NONE;
        len_reg <= LEN_CODE_8;
        stop2_reg <= TWO_STOP_DEFAULT;
      end else if (cfg_write[i] && cfg_baud_div >= DIV_MIN && cfg_baud_div <= DIV_MAX) begin
        div_reg <= cfg_baud_div;
        par_reg <= (cfg_parity == PAR_ODD) ? PAR_ODD : ((cfg_parity == PAR_EVEN) ? PAR_EVEN : PAR_NONE);
        len_reg <= cfg_len;
        stop2_reg <= cfg_two_stop;
        if (i >= NUM_MODEM && cfg_line_mode != 2'h3) begin
          mode_reg <= cfg_line_mode;
        end
      end
    end
    if (i < NUM_MODEM) begin : g_modem
      assign cts_ok = !cts_flow_en[i] || cts_stat[i];
    end else begin : g_multi
      assign cts_ok = 1'b1;
      assign line_mode[i-NUM_MODEM] = mode_reg;
      assign drv_en[i-NUM_MODEM] = drv_reg;
      assign rcv_en[i-NUM_MODEM] = rcv_reg;
    end
    sync_fifo #(.WIDTH(8), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .in_data(tx_data[i]),
      .in_valid(tx_valid[i]),
      .in_ready(tx_ready[i]),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(f_ready)
    );
    // Transmitter. Each bit holds for exactly div_reg clocks.
    assign tx_go = (tx_state == TX_IDLE) && f_valid && cts_ok && !abort_req;
    assign f_ready = tx_go;
    assign tx_done = (tx_state == TX_STOP) && (tx_cnt_reg == '0) && (tx_stop_reg || !stop2_reg);
    assign tx_active_next = !abort_req && (tx_go || ((tx_state != TX_IDLE) && !tx_done));

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        tx_state <= TX_IDLE;
        tx_cnt_reg <= '0;
        tx_idx_reg <= '0;
        tx_sh_reg <= '0;
        tx_par_reg <= 1'b0;
        tx_stop_reg <= 1'b0;
        txd_reg <= 1'b1;
      end else if (abort_req) begin
        tx_state <= TX_IDLE;
        txd_reg <= 1'b1;
      end else if (tx_go) begin
        tx_state <= TX_START;
        tx_cnt_reg <= div_reg - 1'b1;
        tx_sh_reg <= f_data;
        tx_par_reg <= (^(f_data & len_mask)) ^ (par_reg == PAR_ODD);
        tx_idx_reg <= '0;
        tx_stop_reg <= 1'b0;
        txd_reg <= 1'b0;
      end else if (tx_state != TX_IDLE && tx_cnt_reg != '0) begin
        tx_cnt_reg <= tx_cnt_reg - 1'b1;
      end else if (tx_state != TX_IDLE) begin
        tx_cnt_reg <= div_reg - 1'b1;
        unique case (tx_state)
          TX_START: begin
            tx_state <= TX_DATA;
            txd_reg <= tx_sh_reg[0];
          end
          TX_DATA: begin
            if (tx_idx_reg == last_idx) begin
              tx_state <= (par_reg == PAR_NONE) ? TX_STOP : TX_PAR;
              txd_reg <= (par_reg == PAR_NONE) ? 1'b1 : tx_par_reg;
            end else begin
              tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
              txd_reg <= tx_sh_reg[1];
              tx_idx_reg <= tx_idx_reg + 1'b1;
            end
          end
          TX_PAR: begin
            tx_state <= TX_STOP;
            txd_reg <= 1'b1;
          end
          TX_STOP: begin
            tx_stop_reg <= 1'b1;
            if (tx_done) begin
              tx_state <= TX_IDLE;
            end
          end
          TX_IDLE: begin
            txd_reg <= 1'b1;
          end
        endcase
      end
    end
    // In two-wire mode driver control follows the next transmit state so it opens with the start bit; other modes keep both enables on.
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        busy_reg <= 1'b0;
        drv_reg <= 1'b0;
        rcv_reg <= 1'b1;
      end else begin
        busy_reg <= tx_active_next;
        drv_reg <= !is_two_wire || tx_active_next;
        rcv_reg <= !is_two_wire || !tx_active_next;
      end
    end
    // Receiver. Own echo on the shared pair is masked while sending.
    assign rx_line = (is_two_wire && busy_reg) ? 1'b1 : rx_s2_reg;
    assign rx_aligned = rx_sh_reg >> (2'h3 - len_reg);
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        rx_s1_reg <= 1'b1;
        rx_s2_reg <= 1'b1;
        rx_state <= RX_IDLE;
        rx_cnt_reg <= '0;
        rx_idx_reg <= '0;
        rx_sh_reg <= '0;
        rx_par_bit_reg <= 1'b0;
        rx_data_reg <= '0;
        rx_valid_reg <= 1'b0;
        rx_perr_reg <= 1'b0;
        rx_ferr_reg <= 1'b0;
      end else begin
        rx_s1_reg <= rxd[i];
        rx_s2_reg <= rx_s1_reg;
        rx_valid_reg <= 1'b0;
        if (abort_req) begin
          rx_state <= RX_IDLE;
        end else if (rx_state == RX_IDLE) begin
          if (!rx_line) begin
            rx_state <= RX_START;
            rx_cnt_reg <= div_reg >> 1;
          end
        end else if (rx_cnt_reg != '0) begin
          rx_cnt_reg <= rx_cnt_reg - 1'b1;
        end else begin
          rx_cnt_reg <= div_reg - 1'b1;
          unique case (rx_state)
            RX_START: begin
              rx_state <= rx_line ? RX_IDLE : RX_DATA;
              rx_idx_reg <= '0;
            end
            RX_DATA: begin
              rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
              rx_idx_reg <= rx_idx_reg + 1'b1;
              if (rx_idx_reg == last_idx) begin
                rx_state <= (par_reg == PAR_NONE) ? RX_STOP : RX_PAR;
              end
            end
            RX_PAR: begin
              rx_par_bit_reg <= rx_line;
              rx_state <= RX_STOP;
            end
            RX_STOP: begin
              rx_state <= RX_IDLE;
              rx_data_reg <= rx_aligned;
              rx_valid_reg <= 1'b1;
              rx_ferr_reg <= !rx_line;
              rx_perr_reg <= (par_reg != PAR_NONE) &&
                             ((^rx_aligned) ^ (par_reg == PAR_ODD) ^ rx_par_bit_reg);
            end
            RX_IDLE: begin
              rx_state <= RX_IDLE;
            end
          endcase
        end
      end
    end
    assign txd[i] = txd_reg;
    assign tx_busy[i] = busy_reg;
    assign cur_baud_div[i] = div_reg;
    assign rx_data[i] = rx_data_reg;
    assign rx_valid[i] = rx_valid_reg;
    assign rx_parity_err[i] = rx_perr_reg;
    assign rx_frame_err[i] = rx_ferr_reg;
  end
endmodule

// *** quad_async_serial_ports_props.sv ***
// Concurrent checks on the ports of the four-port serial block.
module quad_async_serial_ports_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Configuration
  input wire logic abort_req,
  input wire logic [serial_pkg::NUM_PORTS-1:0] cfg_write,
  input wire logic [serial_pkg::DIV_W-1:0] cfg_baud_div,
  input wire logic [1:0] cfg_line_mode,
  input wire logic [serial_pkg::NUM_PORTS-1:0][serial_pkg::DIV_W-1:0] cur_baud_div,
  // Serial and modem lines
  input wire logic [serial_pkg::NUM_PORTS-1:0] txd,
  input wire logic [serial_pkg::NUM_PORTS-1:0] tx_busy,
  input wire logic [serial_pkg::NUM_MODEM-1:0] rts_req,
  input wire logic [serial_pkg::NUM_MODEM-1:0] dtr_req,
  input wire logic [serial_pkg::NUM_MODEM-1:0] cts_in,
  input wire logic [serial_pkg::NUM_MODEM-1:0] rts_out,
  input wire logic [serial_pkg::NUM_MODEM-1:0] dtr_out,
  input wire logic [serial_pkg::NUM_MODEM-1:0] cts_stat,
  // Line drivers
  input wire logic [1:0][1:0] line_mode,
  input wire logic [1:0] drv_en,
  input wire logic [1:0] rcv_en
);
  timeunit 1ns;
  timeprecision 1ps;
  import serial_pkg::*;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // The synchronisers still hold reset values for a few edges, so history checks wait.
  logic [1:0] up_cnt;
  logic in_range;
  assign in_range = (cfg_baud_div >= DIV_MIN) && (cfg_baud_div <= DIV_MAX);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_modem_out_copy: assert property (up_cnt != 2'h0 |-> rts_out == $past(rts_req) && dtr_out == $past(dtr_req))
    else $error("modem outputs do not follow requests");
  a_cts_two_flop: assert property (up_cnt == 2'h3 |-> cts_stat == $past(cts_in, 2))
    else $error("clear to send status latency wrong");
  a_abort_restore: assert property (abort_req |=> cur_baud_div == {NUM_PORTS{DIV_DEFAULT}})
    else $error("abort did not restore default rate");
  a_rate_accept: assert property (cfg_write[0] && !abort_req && in_range |=> cur_baud_div[0] == $past(cfg_baud_div))
    else $error("legal divisor not taken");
  a_rate_refuse: assert property (cfg_write[0] && !abort_req && !in_range |=> $stable(cur_baud_div[0]))
    else $error("illegal divisor taken");
  a_mode_write: assert property (cfg_write[2] && !abort_req && in_range && cfg_line_mode != 2'h3
    |=> line_mode[0] == $past(cfg_line_mode))
    else $error("line mode not taken");
  a_idle_mark: assert property ((txd | tx_busy) == 4'hf)
    else $error("line low while not sending");
  a_start_low: assert property ($rose(tx_busy[0]) |-> !txd[0] ##1 !txd[0])
    else $error("start bit missing");
  a_two_wire_drive: assert property (line_mode[0] == LINE_RS485 && $past(line_mode[0]) == LINE_RS485
    |-> drv_en[0] == tx_busy[2] && rcv_en[0] == !tx_busy[2])
    else $error("two-wire driver enable wrong");
endmodule
bind quad_async_serial_ports quad_async_serial_ports_props i_quad_async_serial_ports_props (
  .sys_clk(sys_clk), .arst_n(arst_n), .abort_req(abort_req), .cfg_write(cfg_write),
  .cfg_baud_div(cfg_baud_div), .cfg_line_mode(cfg_line_mode), .cur_baud_div(cur_baud_div), .txd(txd),
  .tx_busy(tx_busy), .rts_req(rts_req), .dtr_req(dtr_req), .cts_in(cts_in), .rts_out(rts_out),
  .dtr_out(dtr_out), .cts_stat(cts_stat), .line_mode(line_mode), .drv_en(drv_en), .rcv_en(rcv_en));

// *** serial_terminal.sv ***
// Behavioural terminal on the far side of one serial port.
module serial_terminal (
  // Clock
  input wire logic sys_clk,
  // Serial lines
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxd = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  // Sends one character of eight data bits and one stop bit.
  task automatic send(input logic [7:0] b, input int div);
    int k;
    rxd = 1'b0;
    hold(div);
    for (k = 0; k < 8; k++) begin
      rxd = b[k];
      hold(div);
    end
    rxd = 1'b1;
    hold(div);
  endtask
  // Samples each bit in its middle, so a wrong bit time corrupts the character.
  task automatic recv(input int div, output logic [7:0] b, output bit ok);
    int i;
    i = 0;
    b = 8'h00;
    while (txd !== 1'b0 && i < 20 * div) begin
      hold(1);
      i++;
    end
    ok = (i < 20 * div);
    hold(div / 2);
    ok &= (txd === 1'b0);
    for (i = 0; i < 8; i++) begin
      hold(div);
      b[i] = txd;
    end
    hold(div);
    ok &= (txd === 1'b1);
  endtask
endmodule

// *** quad_async_serial_ports_tb_top.sv ***
// Self-checking bench for the four-port serial block.
module quad_async_serial_ports_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk, arst_n, abort_req, cfg_two_stop, term_rxd;
  logic [3:0] cfg_write, tx_valid, tx_ready, tx_busy, rx_valid, rx_parity_err, rx_frame_err, txd, rxd;
  logic [DIV_W-1:0] cfg_baud_div;
  logic [1:0] cfg_parity, cfg_len, cfg_line_mode, sel, rts_req, dtr_req, cts_flow_en, cts_in, dsr_in, dcd_in;
  logic [1:0] rts_out, dtr_out, cts_stat, dsr_stat, dcd_stat, drv_en, rcv_en;
  logic [3:0][DIV_W-1:0] cur_baud_div;
  logic [3:0][7:0] tx_data, rx_data;
  logic [1:0][1:0] line_mode;
  logic [7:0] got;
  bit ok;
  int miscompares, check_count, cyc, n, i;
  assign rxd = ~(4'h1 << sel) | ({3'h0, term_rxd} << sel);
  quad_async_serial_ports i_quad_async_serial_ports (.sys_clk(sys_clk), .arst_n(arst_n), .abort_req(abort_req),
    .cfg_write(cfg_write), .cfg_baud_div(cfg_baud_div), .cfg_parity(cfg_parity), .cfg_len(cfg_len),
    .cfg_two_stop(cfg_two_stop), .cfg_line_mode(cfg_line_mode), .cur_baud_div(cur_baud_div), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(tx_busy), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err), .txd(txd), .rxd(rxd), .rts_req(rts_req),
    .dtr_req(dtr_req), .cts_flow_en(cts_flow_en), .cts_in(cts_in), .dsr_in(dsr_in), .dcd_in(dcd_in),
    .rts_out(rts_out), .dtr_out(dtr_out), .cts_stat(cts_stat), .dsr_stat(dsr_stat), .dcd_stat(dcd_stat),
    .line_mode(line_mode), .drv_en(drv_en), .rcv_en(rcv_en));
  serial_terminal i_serial_terminal (.sys_clk(sys_clk), .txd(txd[sel]), .rxd(term_rxd));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick;
    @(posedge sys_clk);
    #2;
  endtask
  task automatic chk(input bit good, input string m);
    check_count++;
    if (!good) begin
      miscompares++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset;
    arst_n = 1'b0;
    repeat (16) tick;
    arst_n = 1'b1;
    repeat (2) tick;
    chk(cur_baud_div === {4{DIV_DEFAULT}} && line_mode === {LINE_RS232, LINE_RS232}, "reset config");
    chk(txd === 4'hf && tx_ready === 4'hf && tx_busy === 4'h0, "reset lines");
  endtask
  task automatic cfg(input int p, input logic [DIV_W-1:0] div, input logic [1:0] mode);
    cfg_write = 4'h1 << p;
    cfg_baud_div = div;
    cfg_line_mode = mode;
    tick;
    cfg_write = 4'h0;
    tick;
  endtask
  task automatic put(input int p, input logic [7:0] b);
    tx_data[p] = b;
    tx_valid[p] = 1'b1;
    i = 0;
    while (tx_ready[p] !== 1'b1 && i < 1000) begin
      tick;
      i++;
    end
    tick;
    tx_valid[p] = 1'b0;
  endtask
  // Sends one character and times how long the port stays busy with it.
  task automatic txchk(input int p, input logic [7:0] b, input int div, input int bits);
    put(p, b);
    n = 0;
    fork
      i_serial_terminal.recv(div, got, ok);
      begin
        repeat (10) if (tx_busy[p] !== 1'b1) tick;
        while (tx_busy[p] === 1'b1 && n < 20 * div) begin
          tick;
          n++;
        end
      end
    join
    chk(ok && got === b, "character on line");
    chk(n >= bits * div - 2 && n <= bits * div + 2, "character time");
  endtask
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 98000) begin
      miscompares++;
      close_out;
    end
  end
  initial begin
    {abort_req, cfg_write, tx_valid, tx_data, sel, rts_req, dtr_req, cts_flow_en, cts_in, dsr_in, dcd_in} = '0;
    cfg_baud_div = DIV_DEFAULT;
    cfg_parity = PAR_NONE;
    cfg_len = LEN_CODE_8;
    cfg_two_stop = TWO_STOP_DEFAULT;
    cfg_line_mode = LINE_RS232;
    do_reset;
    txchk(0, 8'ha5, DIV_DEFAULT, 10);
    for (n = 0; n < 4; n++) begin
      cfg(2, DIV_DEFAULT, n[1:0]);
      chk(line_mode[0] === ((n == 3) ? LINE_RS485 : n[1:0]), "line mode");
    end
    chk(drv_en[0] === 1'b0 && rcv_en[0] === 1'b1, "two-wire idle");
    cfg(0, DIV_MIN - 1, 2'h3);
    chk(cur_baud_div[0] === DIV_DEFAULT, "fast divisor taken");
    cfg(0, DIV_MAX, 2'h3);
    chk(cur_baud_div[0] === DIV_MAX, "slowest divisor refused");
    cfg(0, DIV_MAX + 1, 2'h3);
    chk(cur_baud_div[0] === DIV_MAX, "slow divisor taken");
    for (int p = 0; p < 4; p++) begin
      sel = p[1:0];
      // Port two runs seven data bits, even parity and two stops, so its parity bit is the eighth sample.
      cfg_parity = (p == 1) ? PAR_EVEN : PAR_NONE;
      cfg_len = (p == 1) ? 2'h2 : LEN_CODE_8;
      cfg_two_stop = (p == 1);
      cfg(p, DIV_MIN, 2'h3);
      chk(cur_baud_div[p] === DIV_MIN && (p == 3 || cur_baud_div[3] === DIV_DEFAULT), "port divisor");
      txchk(p, (p == 1) ? 8'hdb : 8'h5a ^ p[7:0], DIV_MIN, (p == 1) ? 11 : 10);
    end
    // Seven data bits with odd parity, so the top bit of the byte arrives as a wrong parity bit.
    cfg_parity = PAR_ODD;
    cfg_len = 2'h2;
    cfg(3, DIV_MIN, 2'h3);
    fork
      i_serial_terminal.send(8'hc3, DIV_MIN);
      begin
        i = 0;
        while (rx_valid[3] !== 1'b1 && i < 12 * DIV_MIN) begin
          tick;
          i++;
        end
        chk(rx_valid[3] === 1'b1 && rx_data[3] === 8'h43, "received character");
        chk(rx_parity_err[3] === 1'b1 && rx_frame_err[3] === 1'b0, "receive error flags");
      end
    join
    cfg_parity = PAR_NONE;
    cfg_len = LEN_CODE_8;
    {rts_req, dtr_req, dsr_in, dcd_in, cts_in} = {2'h2, 2'h1, 2'h3, 2'h2, 2'h1};
    repeat (3) tick;
    chk({rts_out, dtr_out, dsr_stat, dcd_stat, cts_stat} === 10'h279, "modem lines");
    sel = 2'h0;
    put(0, 8'hff);
    repeat (50) tick;
    chk(tx_busy[0] === 1'b1, "sending before abort");
    abort_req = 1'b1;
    tick;
    abort_req = 1'b0;
    repeat (2) tick;
    chk(tx_busy[0] === 1'b0 && cur_baud_div === {4{DIV_DEFAULT}} && line_mode[0] === LINE_RS485, "abort");
    cfg(0, DIV_MIN, 2'h3);
    cts_flow_en = 2'h1;
    cts_in = 2'h0;
    repeat (3) tick;
    n = 0;
    tx_valid[0] = 1'b1;
    repeat (40) begin
      tx_data[0] = 8'h10 + n[7:0];
      if (tx_ready[0] === 1'b1) n++;
      tick;
    end
    tx_valid[0] = 1'b0;
    chk(n == 33 && tx_busy[0] === 1'b0, "buffer fill under flow hold");
    cts_in = 2'h1;
    for (int k = 0; k < 2; k++) begin
      i_serial_terminal.recv(DIV_MIN, got, ok);
      chk(ok && got === 8'h10 + k[7:0], "buffer order");
    end
    do_reset;
    close_out;
  end
endmodule
